// [hw/power_mode_pkg.sv]
`default_nettype none
package power_mode_pkg;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned OSC_STARTUP_NS = 10000;
	localparam int unsigned PLL_LOCK_NS = 5000;
	localparam int unsigned OSC_STARTUP_CYC = (OSC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DELAY_W = 13;
	localparam int unsigned PERIPH_N = 8;
	localparam int unsigned PRIO_W = 3;
	localparam int unsigned OSC_CTRL_W = 32;
	localparam int unsigned SLEEP_SEL_BIT = 4;
	localparam int unsigned PB_DIV_LSB = 19;
	localparam int unsigned PB_DIV_W = 2;
	localparam int unsigned PB_CNT_W = 3;
	localparam logic [PB_CNT_W-1:0] PB_CNT_RST = 3'h0;
	localparam logic [DELAY_W-1:0] DELAY_RST = 13'h0000;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_IDLE = 3'b001,
		ST_SLEEP = 3'b010,
		ST_STARTUP = 3'b011,
		ST_SWITCH = 3'b100
	} power_state_type;

	typedef enum logic [2:0] {
		SRC_POSC = 3'b000,
		SRC_POSC_PLL = 3'b001,
		SRC_FAST = 3'b010,
		SRC_FAST_DIV = 3'b011,
		SRC_LOW_POWER = 3'b100,
		SRC_SECONDARY = 3'b101
	} osc_src_type;

	localparam osc_src_type SRC_RST = SRC_FAST;

	typedef struct packed {
		logic valid;
		logic sleep_capable;
		logic [PRIO_W-1:0] priority_level;
	} irq_req_type;

	typedef struct packed {
		logic cpu_en;
		logic sys_src_en;
		logic sys_direct_en;
		logic pb_tick;
		logic monitor_en;
		logic fast_osc_en;
		logic low_power_osc_en;
		logic io_drive_en;
	} clk_gates_type;

	localparam clk_gates_type GATES_RST = 8'hff;
endpackage
`default_nettype wire

// [hw/power_mode_ctrl.sv]
`default_nettype none
// Behaviour
// [R1] Sleep and Idle both stop the CPU core clock.
// [R2] Idle halts the CPU but keeps the system clock source running.
// [R3] In Idle, peripherals with their stop-in-idle bit set halt; others run.
// [R4] Wait instruction with sleep-on-wait select clear enters Idle.
// [R5] Wait instruction with sleep-on-wait select set enters Sleep.
// [R6] Sleep halts CPU, system clock source and its peripherals.
// [R7] Fail-safe clock monitor is inactive throughout Sleep.
// [R8] Entering Sleep never clears the watchdog; its count carries on.
// [R9] Sleep-capable peripherals keep running in Sleep and may wake the device.
// [R10] I/O pins keep driving their levels in Sleep.
// [R11] USB may keep the primary or fast oscillator running in Sleep.
// [R12] Sleep wakes on enabled sleep-capable interrupt with priority above CPU.
// [R13] Lower or equal priority wake keeps CPU halted, restarts bus clock, enters Idle.
// [R14] Any device reset or watchdog time-out leaves Sleep or Idle.
// [R15] Idle exits on interrupt above CPU priority; otherwise stays in Idle.
// [R16] Crystal or PLL source restarts get start-up and lock delays; Idle exit none.
// [R17] Running CPU may use fast, divided fast, low-power or secondary oscillators.
// [R18] Idle works with any system clock source; peripherals keep running.
// [R19] Peripheral bus clock runs at a programmable fraction of the system clock.
// [R20] Divider ratios are 1, 2, 4 and 8; direct system clock users unaffected.
module power_mode_ctrl
	import power_mode_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic wait_exec_in,
	input wire logic [OSC_CTRL_W-1:0] oscillator_control_register_in,
	input wire logic osc_switch_req_in,
	input wire osc_src_type osc_new_src_in,
	input wire irq_req_type irq_in,
	input wire logic [PRIO_W-1:0] cpu_priority_in,
	input wire logic watchdog_timeout_in,
	input wire logic reset_event_in,
	input wire logic [PERIPH_N-1:0] stop_in_idle_bit_in,
	input wire logic usb_osc_hold_in,
	output var clk_gates_type gates_out,
	output logic [PERIPH_N-1:0] periph_clk_en_out,
	output var osc_src_type sys_src_out,
	output var power_state_type power_state_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Decode of inputs.

	power_state_type state_r;
	power_state_type state_nxt;
	power_state_type target_r;
	power_state_type target_nxt;
	osc_src_type sys_src_r;
	osc_src_type sys_src_nxt;
	osc_src_type pend_src_r;
	osc_src_type pend_src_nxt;
	logic [DELAY_W-1:0] cnt_r;
	logic [DELAY_W-1:0] cnt_nxt;
	logic [PB_CNT_W-1:0] pb_cnt_r;
	logic [PB_CNT_W-1:0] pb_cnt_nxt;
	clk_gates_type gates_r;
	clk_gates_type gates_nxt;
	logic [PERIPH_N-1:0] periph_r;
	logic [PERIPH_N-1:0] periph_nxt;

	function automatic logic [DELAY_W-1:0] start_delay(input osc_src_type src);
		logic [DELAY_W-1:0] d;
		d = DELAY_RST;
		if (src == SRC_POSC || src == SRC_POSC_PLL || src == SRC_SECONDARY) begin
			d = DELAY_W'(OSC_STARTUP_CYC);
		end
		if (src == SRC_POSC_PLL) begin
			d = DELAY_W'(OSC_STARTUP_CYC + PLL_LOCK_CYC);
		end
		return d;
	endfunction

	wire sleep_sel = oscillator_control_register_in[SLEEP_SEL_BIT];
	wire [PB_DIV_W-1:0] pb_div = oscillator_control_register_in[PB_DIV_LSB +: PB_DIV_W];
	wire wake_hi = irq_in.valid && (irq_in.priority_level > cpu_priority_in);
	wire sleep_irq = irq_in.valid && irq_in.sleep_capable;
	wire exit_evt = reset_event_in || watchdog_timeout_in;
	wire src_fast_family = (sys_src_r == SRC_POSC) || (sys_src_r == SRC_POSC_PLL)
		|| (sys_src_r == SRC_FAST) || (sys_src_r == SRC_FAST_DIV);
	// The USB unit may hold the primary or fast source alive through Sleep.
	wire src_kept = usb_osc_hold_in && src_fast_family; // [R11]
	wire [DELAY_W-1:0] cur_delay = start_delay(sys_src_r);
	wire [DELAY_W-1:0] new_delay = start_delay(osc_new_src_in);
	wire wake_needs_delay = (cur_delay != DELAY_RST) && !src_kept; // [R16]
	wire switch_req = osc_switch_req_in && (osc_new_src_in != sys_src_r);
	wire [PB_CNT_W-1:0] pb_mask = (pb_div == 2'h0) ? 3'h0 :
		(pb_div == 2'h1) ? 3'h1 :
		(pb_div == 2'h2) ? 3'h3 : 3'h7; // [R20]
	wire st_idle_nxt = (state_nxt == ST_IDLE);
	wire st_sleep_nxt = (state_nxt == ST_SLEEP);
	wire direct_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_IDLE)
		|| (state_nxt == ST_SWITCH);

	////////////////////////////////////////////////////////////////////////////////
	// Power state sequencing.

	always_comb begin
		state_nxt = state_r;
		target_nxt = target_r;
		cnt_nxt = cnt_r;
		sys_src_nxt = sys_src_r;
		pend_src_nxt = pend_src_r;
		unique case (state_r)
			ST_RUN: begin
				if (switch_req) begin
					// A crystal or PLL source waits; other sources switch at once.
					if (new_delay != DELAY_RST) begin // [R16]
						pend_src_nxt = osc_new_src_in;
						cnt_nxt = new_delay - 13'h0001;
						state_nxt = ST_SWITCH;
					end else begin
						sys_src_nxt = osc_new_src_in; // [R17]
					end
				end else if (wait_exec_in) begin
					// The watchdog is not touched here, so its count carries on.
					state_nxt = sleep_sel ? ST_SLEEP : ST_IDLE; // [R4] [R5] [R8]
				end
			end
			ST_IDLE: begin
				if (exit_evt || wake_hi) begin // [R14] [R15]
					state_nxt = ST_RUN;
				end
			end
			ST_SLEEP: begin
				if (exit_evt || sleep_irq) begin // [R9] [R12] [R14]
					target_nxt = (exit_evt || wake_hi) ? ST_RUN : ST_IDLE; // [R13]
					if (wake_needs_delay) begin // [R16]
						cnt_nxt = cur_delay - 13'h0001;
						state_nxt = ST_STARTUP;
					end else begin
						state_nxt = (exit_evt || wake_hi) ? ST_RUN : ST_IDLE;
					end
				end
			end
			ST_STARTUP: begin
				if (target_r == ST_IDLE && (exit_evt || wake_hi)) begin
					target_nxt = ST_RUN;
				end
				if (cnt_r == DELAY_RST) begin
					state_nxt = target_nxt;
				end else begin
					cnt_nxt = cnt_r - 13'h0001;
				end
			end
			ST_SWITCH: begin
				// The old source keeps clocking the CPU until the new one is ready.
				if (cnt_r == DELAY_RST) begin
					sys_src_nxt = pend_src_r;
					state_nxt = ST_RUN;
				end else begin
					cnt_nxt = cnt_r - 13'h0001;
				end
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clock gates and peripheral bus divider.

	always_comb begin
		gates_nxt.cpu_en = (state_nxt == ST_RUN) || (state_nxt == ST_SWITCH); // [R1]
		gates_nxt.sys_src_en = !st_sleep_nxt || src_kept; // [R2] [R6] [R18]
		gates_nxt.sys_direct_en = direct_nxt; // [R6] [R20]
		gates_nxt.pb_tick = direct_nxt && ((pb_cnt_r & pb_mask) == pb_mask); // [R19]
		gates_nxt.monitor_en = !st_sleep_nxt; // [R7]
		gates_nxt.fast_osc_en = (!st_sleep_nxt && src_fast_family) || usb_osc_hold_in; // [R11]
		gates_nxt.low_power_osc_en = 1'b1; // [R9]
		gates_nxt.io_drive_en = 1'b1; // [R10]
		pb_cnt_nxt = direct_nxt ? pb_cnt_r + 3'h1 : PB_CNT_RST;
		periph_nxt = {PERIPH_N{gates_nxt.pb_tick}}
			& ~({PERIPH_N{st_idle_nxt}} & stop_in_idle_bit_in); // [R3]
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= ST_RUN;
			target_r <= ST_RUN;
			cnt_r <= DELAY_RST;
			sys_src_r <= SRC_RST;
			pend_src_r <= SRC_RST;
			pb_cnt_r <= PB_CNT_RST;
			gates_r <= GATES_RST;
			periph_r <= {PERIPH_N{1'b1}};
		end else begin
			state_r <= state_nxt;
			target_r <= target_nxt;
			cnt_r <= cnt_nxt;
			sys_src_r <= sys_src_nxt;
			pend_src_r <= pend_src_nxt;
			pb_cnt_r <= pb_cnt_nxt;
			gates_r <= gates_nxt;
			periph_r <= periph_nxt;
		end
	end

	assign gates_out = gates_r;
	assign periph_clk_en_out = periph_r;
	assign sys_src_out = sys_src_r;
	assign power_state_out = state_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_wait_in_run;
		state_r == ST_RUN && !switch_req && wait_exec_in;
	endsequence

	sequence s_halted_sleep;
		state_r == ST_SLEEP && !gates_out.cpu_en && !gates_out.monitor_en;
	endsequence

	property p_enter_sleep;
		s_wait_in_run and (sleep_sel == 1'b1) |=> s_halted_sleep;
	endproperty
	a_enter_sleep: assert property (p_enter_sleep) // [R5]
		else $error("wait with sleep select did not enter sleep");

	property p_enter_idle;
		s_wait_in_run and (sleep_sel == 1'b0)
			|=> state_r == ST_IDLE && !gates_out.cpu_en && gates_out.sys_src_en;
	endproperty
	a_enter_idle: assert property (p_enter_idle) // [R4]
		else $error("wait without sleep select did not enter idle");

	property p_cpu_halted;
		(state_r == ST_IDLE || state_r == ST_SLEEP) |-> !gates_out.cpu_en;
	endproperty
	a_cpu_halted: assert property (p_cpu_halted) // [R1]
		else $error("cpu clock running while halted");

	property p_monitor_off;
		state_r == ST_SLEEP |-> !gates_out.monitor_en && !gates_out.sys_direct_en;
	endproperty
	a_monitor_off: assert property (p_monitor_off) // [R7]
		else $error("monitor or system clock active in sleep");

	property p_idle_stop;
		state_r == ST_IDLE && stop_in_idle_bit_in[0] && !exit_evt && !wake_hi
			|=> !periph_clk_en_out[0];
	endproperty
	a_idle_stop: assert property (p_idle_stop) // [R3]
		else $error("stopped peripheral clocked in idle");

	property p_sleep_wake;
		state_r == ST_SLEEP && sleep_irq && wake_hi && !wake_needs_delay
			|=> state_r == ST_RUN && gates_out.cpu_en;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) // [R12]
		else $error("high priority interrupt did not wake from sleep");

	property p_sleep_low;
		state_r == ST_SLEEP && sleep_irq && !wake_hi && !exit_evt && !wake_needs_delay
			|=> state_r == ST_IDLE && gates_out.sys_direct_en && !gates_out.cpu_en;
	endproperty
	a_sleep_low: assert property (p_sleep_low) // [R13]
		else $error("low priority sleep interrupt did not move to idle");

	property p_idle_stay;
		state_r == ST_IDLE && !wake_hi && !exit_evt |=> state_r == ST_IDLE;
	endproperty
	a_idle_stay: assert property (p_idle_stay) // [R15]
		else $error("idle left without a wake event");

	property p_idle_exit;
		state_r == ST_IDLE && exit_evt |=> state_r == ST_RUN && gates_out.cpu_en;
	endproperty
	a_idle_exit: assert property (p_idle_exit) // [R14]
		else $error("reset or watchdog did not leave idle");

	property p_pb_full_rate;
		direct_nxt && pb_div == 2'h0 |=> gates_out.pb_tick;
	endproperty
	a_pb_full_rate: assert property (p_pb_full_rate) // [R20]
		else $error("one to one bus clock missed a tick");

	property p_startup_hold;
		state_r == ST_STARTUP && cnt_r != DELAY_RST |=> state_r == ST_STARTUP;
	endproperty
	a_startup_hold: assert property (p_startup_hold) // [R16]
		else $error("start-up delay cut short");

	sequence s_sleep_next;
		st_sleep_nxt && !src_kept;
	endsequence

	property p_sleep_src_off;
		s_sleep_next |=> !gates_out.sys_src_en && periph_clk_en_out == {PERIPH_N{1'b0}};
	endproperty
	a_sleep_src_off: assert property (p_sleep_src_off) // [R6]
		else $error("system clock source or bus clock running in sleep");

	property p_usb_keep;
		usb_osc_hold_in |=> gates_out.fast_osc_en;
	endproperty
	a_usb_keep: assert property (p_usb_keep) // [R11]
		else $error("held oscillator stopped");

	property p_idle_src_on;
		state_r == ST_IDLE |-> gates_out.sys_src_en && gates_out.sys_direct_en;
	endproperty
	a_idle_src_on: assert property (p_idle_src_on) // [R2] [R18]
		else $error("system clock stopped in idle");

	property p_idle_run_periph;
		state_r == ST_IDLE && !stop_in_idle_bit_in[PERIPH_N-1] && pb_div == 2'h0
			&& !exit_evt && !wake_hi |=> periph_clk_en_out[PERIPH_N-1];
	endproperty
	a_idle_run_periph: assert property (p_idle_run_periph) // [R3]
		else $error("running peripheral not clocked in idle");

	sequence s_quick_switch;
		state_r == ST_RUN && switch_req && new_delay == DELAY_RST;
	endsequence

	property p_switch_now;
		s_quick_switch |=> sys_src_out == $past(osc_new_src_in) && state_r == ST_RUN;
	endproperty
	a_switch_now: assert property (p_switch_now) // [R17]
		else $error("direct source switch not taken at once");

	property p_switch_hold;
		state_r == ST_SWITCH && cnt_r != DELAY_RST
			|=> state_r == ST_SWITCH && gates_out.cpu_en && $stable(sys_src_out);
	endproperty
	a_switch_hold: assert property (p_switch_hold) // [R16]
		else $error("source changed before start-up delay ended");

	property p_sleep_exit;
		state_r == ST_SLEEP && exit_evt && !wake_needs_delay
			|=> state_r == ST_RUN && gates_out.cpu_en;
	endproperty
	a_sleep_exit: assert property (p_sleep_exit) // [R14]
		else $error("reset or watchdog did not leave sleep");

	property p_sleep_delay;
		state_r == ST_SLEEP && (exit_evt || sleep_irq) && wake_needs_delay
			|=> state_r == ST_STARTUP && !gates_out.cpu_en;
	endproperty
	a_sleep_delay: assert property (p_sleep_delay) // [R16]
		else $error("crystal source woke without start-up delay");

	// A changed divider may legally tick twice in a row, so only a steady ratio is held to it.
	property p_pb_divide;
		gates_out.pb_tick && pb_div != 2'h0 && $stable(pb_div) |=> !gates_out.pb_tick;
	endproperty
	a_pb_divide: assert property (p_pb_divide) // [R19] [R20]
		else $error("divided bus clock ticked twice in a row");
endmodule
`default_nettype wire

// [test/cpu_irq_model.sv]
`default_nettype none
// The CPU core and the interrupt controller, seen from the block.
// Both answer one cycle after the bench asks, as registered logic would.
module cpu_irq_model
	import power_mode_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic wait_req_in,
	input wire irq_req_type irq_set_in,
	input wire logic [PRIO_W-1:0] prio_set_in,
	output logic wait_exec_out,
	output var irq_req_type irq_out,
	output logic [PRIO_W-1:0] cpu_priority_out
);
	logic req_d_r;
	always_ff @(posedge clk_sys_in) begin
		req_d_r <= wait_req_in;
		wait_exec_out <= wait_req_in & ~req_d_r;
		irq_out <= irq_set_in;
		cpu_priority_out <= prio_set_in;
	end
endmodule
`default_nettype wire

// [test/power_mode_ctrl_tb_top.sv]
`default_nettype none
module power_mode_ctrl_tb_top
	import power_mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic wreq = 1'b0;
	logic sw_req = 1'b0;
	logic watchdog_to = 1'b0;
	logic rst_ev = 1'b0;
	logic usb_hold = 1'b0;
	logic [OSC_CTRL_W-1:0] osc_ctrl = '0;
	osc_src_type new_src = SRC_FAST;
	irq_req_type irq_set = '0;
	logic [PRIO_W-1:0] prio_set = 3'h3;
	logic [PERIPH_N-1:0] stop_bits = '0;
	logic wait_exec;
	irq_req_type irq;
	logic [PRIO_W-1:0] cpu_prio;
	clk_gates_type gates;
	logic [PERIPH_N-1:0] pen;
	osc_src_type src;
	power_state_type st;
	int bad_count = 0;
	int n_compared = 0;

	always #2.5 clk_sys_in = ~clk_sys_in;

	cpu_irq_model partner (.clk_sys_in(clk_sys_in), .wait_req_in(wreq), .irq_set_in(irq_set),
		.prio_set_in(prio_set), .wait_exec_out(wait_exec), .irq_out(irq),
		.cpu_priority_out(cpu_prio));

	power_mode_ctrl dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wait_exec_in(wait_exec),
		.oscillator_control_register_in(osc_ctrl), .osc_switch_req_in(sw_req),
		.osc_new_src_in(new_src), .irq_in(irq), .cpu_priority_in(cpu_prio),
		.watchdog_timeout_in(watchdog_to), .reset_event_in(rst_ev), .stop_in_idle_bit_in(stop_bits),
		.usb_osc_hold_in(usb_hold), .gates_out(gates), .periph_clk_en_out(pen),
		.sys_src_out(src), .power_state_out(st));

	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (bad_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Outputs are sampled 1 ns after the edge so the edge's own updates have landed.
	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge clk_sys_in);
			#1;
		end
	endtask

	task automatic wait_st(input power_state_type exp, input int lim);
		int i;
		for (i = 0; i < lim && st !== exp; i++) cyc(1);
		chk(8'(st), 8'(exp));
		if (st !== exp) tally_and_finish();
	endtask

	task automatic go_wait(input logic sel);
		@(posedge clk_sys_in);
		osc_ctrl[SLEEP_SEL_BIT] <= sel;
		wreq <= 1'b1;
		@(posedge clk_sys_in);
		wreq <= 1'b0;
		#1;
	endtask

	task automatic set_irq(input irq_req_type v);
		@(posedge clk_sys_in);
		irq_set <= v;
		#1;
	endtask

	task automatic kick(input logic w);
		@(posedge clk_sys_in);
		watchdog_to <= w;
		rst_ev <= ~w;
		@(posedge clk_sys_in);
		watchdog_to <= 1'b0;
		rst_ev <= 1'b0;
		#1;
	endtask

	task automatic sw(input osc_src_type s);
		@(posedge clk_sys_in);
		sw_req <= 1'b1;
		new_src <= s;
		@(posedge clk_sys_in);
		sw_req <= 1'b0;
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic s_idle();
		logic [7:0] seen;
		seen = '0;
		@(posedge clk_sys_in);
		stop_bits <= 8'h0f;
		go_wait(1'b0);
		wait_st(ST_IDLE, 6);
		chk(8'({gates.cpu_en, gates.sys_src_en}), 8'h1);
		repeat (4) begin
			cyc(1);
			seen = seen | pen;
		end
		chk(seen, 8'hf0);
		set_irq(5'b10010);
		cyc(6);
		chk(8'(st), 8'(ST_IDLE));
		set_irq(5'b10101);
		wait_st(ST_RUN, 4);
		set_irq(5'b00000);
	endtask

	task automatic s_sleep();
		@(posedge clk_sys_in);
		usb_hold <= 1'b1;
		go_wait(1'b1);
		wait_st(ST_SLEEP, 6);
		chk(8'({gates.cpu_en, gates.sys_direct_en}), 8'h0);
		chk(8'({gates.monitor_en, gates.io_drive_en}), 8'h1);
		chk(pen, 8'h00);
		chk(8'({gates.fast_osc_en, gates.sys_src_en, gates.low_power_osc_en}), 8'h7);
		set_irq(5'b10110);
		cyc(6);
		chk(8'(st), 8'(ST_SLEEP));
		set_irq(5'b11001);
		wait_st(ST_IDLE, 4);
		chk(8'({gates.cpu_en, gates.sys_direct_en}), 8'h1);
		set_irq(5'b00000);
		kick(1'b1);
		wait_st(ST_RUN, 4);
		go_wait(1'b1);
		wait_st(ST_SLEEP, 6);
		set_irq(5'b11110);
		wait_st(ST_RUN, 4);
		set_irq(5'b00000);
		@(posedge clk_sys_in);
		usb_hold <= 1'b0;
		go_wait(1'b1);
		wait_st(ST_SLEEP, 6);
		chk(8'({gates.sys_src_en, gates.fast_osc_en}), 8'h0);
		kick(1'b0);
		wait_st(ST_RUN, 4);
	endtask

	// Any 16-cycle window holds exactly 16/ratio ticks, whatever the divider's phase.
	task automatic s_clocks();
		int n;
		int d;
		sw(SRC_LOW_POWER);
		chk(8'(src), 8'(SRC_LOW_POWER));
		for (d = 0; d < 4; d++) begin
			@(posedge clk_sys_in);
			osc_ctrl[PB_DIV_LSB +: PB_DIV_W] <= PB_DIV_W'(d);
			cyc(8);
			n = 0;
			repeat (16) begin
				cyc(1);
				n += int'(gates.pb_tick === 1'b1);
			end
			chk(8'(n), 8'(16 >> d));
			chk(8'(gates.sys_direct_en), 8'h1);
		end
		sw(SRC_POSC);
		wait_st(ST_SWITCH, 2);
		chk(8'({gates.cpu_en, src}), 8'({1'b1, SRC_LOW_POWER}));
		n = 0;
		while (n < 2100 && st === ST_SWITCH) begin
			cyc(1);
			n++;
		end
		chk(8'(n >= OSC_STARTUP_CYC - 2 && n <= OSC_STARTUP_CYC + 2), 8'h1);
		chk(8'(src), 8'(SRC_POSC));
		go_wait(1'b0);
		wait_st(ST_IDLE, 6);
		set_irq(5'b10101);
		wait_st(ST_RUN, 4);
		set_irq(5'b00000);
		go_wait(1'b1);
		wait_st(ST_SLEEP, 6);
		kick(1'b1);
		wait_st(ST_STARTUP, 3);
		wait_st(ST_RUN, 2100);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		cyc(2);
		s_idle();
		s_sleep();
		s_clocks();
		tally_and_finish();
	end
endmodule
`default_nettype wire
